// file: core/airb_core.sv
// Alarm and interrupt register bank with its serial host port.
// Assumes alarm inputs come from logic on ref_clk; the serial pins come
// from the host and are synchronised here. SClk must stay below ref_clk/8.
//
// Function
// R1: Bit 4 at 0x00 switches receiver.
// R2: Bit 0 at 0x00 switches transmitter, tristates.
// R3: Enable D0 gates driver-failure interrupt.
// R4: Enables D1, D2 gate signal/lock loss.
// R5: Enable D3 gates FIFO edge, needs attenuator.
// R6: Enable D4 gates pattern bit error.
// R7: Enable D5 gates counter saturation interrupt.
// R8: Status D0-D3 latch changes, clear on read.
// R9: Status D4 latches pattern error, clear-on-read.
// R10: Status D5 latches saturation, clear on read.
// R11: Alarm D0 shows driver monitor failure.
// R12: Alarm D1 shows signal loss.
// R13: Alarm D2 shows lock loss.
// R14: Alarm D3 shows FIFO near edge.
// R15: Alarm D4 shows analog signal loss.
// R16: Alarm D5 shows digital signal loss.
// R17: Alarm D6 shows pattern bit error.
// R18: Identification bytes at 0x3E and 0x3F.
// R19: Interrupt output is active low.
// R20: Reading FIFO alarm recentres FIFO, clears alarm.
// R21: Global gate and pending OR of enabled.
// R22: Sixteen-bit saturating error counter, two bytes.
`timescale 1ns/1ps
`default_nettype none

module airb_core
  import airb_pkg::*;
#(
  // Arbitrary neutral identification values
  parameter logic [7:0] PART_ID = 8'h5a,
  parameter logic [7:0] REVISION_ID = 8'h01
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire airb_alarm_in_t alarm_in,
  input wire logic host_sclk,
  input wire logic host_sdi,
  input wire logic host_cs,
  output logic host_sdo,
  output logic host_sdo_oe,
  output logic host_irq_n,
  output airb_ctrl_out_t ctrl_out
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] sclk_q, sclk_d;
  logic [1:0] sdi_q, sdi_d;
  logic [1:0] cs_q, cs_d;

  always_comb
  begin
    sclk_d = {sclk_q[1:0], host_sclk};
    sdi_d = {sdi_q[0], host_sdi};
    cs_d = {cs_q[0], host_cs};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 3'h0;
      sdi_q <= 2'h0;
      cs_q <= 2'h0;
    end
    else
    begin
      sclk_q <= sclk_d;
      sdi_q <= sdi_d;
      cs_q <= cs_d;
    end
  end

  logic sclk_rise;
  logic cs_on;
  logic sdi_bit;

  always_comb
  begin
    sclk_rise = sclk_q[1] & ~sclk_q[2];
    cs_on = cs_q[1];
    sdi_bit = sdi_q[1];
  end

  // ------------------------------------------------------------------
  // Serial frame engine
  // ------------------------------------------------------------------
  airb_state_t state_q, state_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic rd_q, rd_d;
  logic [6:0] addr_q, addr_d;
  logic sdo_q, sdo_d;
  logic sdo_oe_q, sdo_oe_d;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;

  always_comb
  begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    rd_d = rd_q;
    addr_d = addr_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    case (state_q)
      AIRB_IDLE:
      begin
        bitcnt_d = BITCNT_RST;
        if (cs_on)
          state_d = AIRB_HDR;
      end
      AIRB_HDR:
      begin
        if (sclk_rise)
        begin
          bitcnt_d = bitcnt_q + BITCNT_STEP;
          shift_d = {shift_q[6:0], sdi_bit};
          if (bitcnt_q == HDR_LAST_BIT)
          begin
            rd_d = shift_q[6];
            addr_d = {shift_q[5:0], sdi_bit};
            state_d = AIRB_DATA;
            if (shift_q[6])
            begin
              // Side effects of a read happen once, when the byte is fetched
              rd_stb = 1'b1;
              tx_d = {rdata[6:0], 1'b0};
              sdo_d = rdata[7];
              sdo_oe_d = 1'b1;
            end
          end
        end
      end
      AIRB_DATA:
      begin
        if (sclk_rise)
        begin
          bitcnt_d = bitcnt_q + BITCNT_STEP;
          shift_d = {shift_q[6:0], sdi_bit};
          sdo_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
          if (bitcnt_q == FRAME_LAST_BIT)
          begin
            wr_stb = ~rd_q;
            state_d = AIRB_DONE;
          end
        end
      end
      AIRB_DONE:
      begin
        sdo_oe_d = 1'b0;
      end
      default:
        state_d = AIRB_IDLE;
    endcase
    if (!cs_on)
    begin
      state_d = AIRB_IDLE;
      sdo_oe_d = 1'b0;
      sdo_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= AIRB_IDLE;
      bitcnt_q <= BITCNT_RST;
      shift_q <= RST_BYTE;
      tx_q <= RST_BYTE;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  // Read address is the one just completed in the header
  logic [6:0] rd_addr;
  always_comb
    rd_addr = {shift_q[5:0], sdi_bit};

  // Write data must include the bit sampled at the closing rise
  logic [7:0] wdata;
  always_comb
    wdata = {shift_q[6:0], sdi_bit};

  // ------------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------------
  logic rx_on_q, rx_on_d;
  logic tx_on_q, tx_on_d;
  logic [NUM_IRQ_SRC-1:0] irq_en_q, irq_en_d;
  logic [NUM_IRQ_SRC-1:0] irq_lat_q, irq_lat_d;
  logic gate_q, gate_d;
  logic [3:0] prev_q, prev_d;
  logic fl_q, fl_d;
  logic recentre_q, recentre_d;
  logic [15:0] err_cnt_q, err_cnt_d;
  logic [7:0] hold_q, hold_d;
  logic irq_n_q, irq_n_d;
  logic [NUM_IRQ_SRC-1:0] irq_evt;
  logic [NUM_IRQ_SRC-1:0] en_eff;
  logic [3:0] live4;
  logic pending;
  logic sat_evt;

  always_comb
  begin
    live4 = {fl_q, alarm_in.lock_loss_alarm, alarm_in.signal_loss_alarm,
             alarm_in.driver_fail_alarm};
    sat_evt = alarm_in.pattern_error_pulse && (err_cnt_q == ERR_COUNT_SAT - 16'h0001);
    irq_evt = {sat_evt, alarm_in.pattern_error_pulse, live4 ^ prev_q}; // R8 R9 R10
    en_eff = irq_en_q;
    en_eff[BIT_FIFO_EDGE] = irq_en_q[BIT_FIFO_EDGE] & alarm_in.jitter_atten_enabled; // R5
    pending = |(irq_lat_q & en_eff); // R3 R4 R6 R7 R21
  end

  always_comb
  begin
    rdata = RST_BYTE;
    case (rd_addr)
      ADDR_LINE_POWER_CONTROL:
      begin
        rdata[BIT_RECEIVER_POWER_ON] = rx_on_q;
        rdata[BIT_TRANSMITTER_POWER_ON] = tx_on_q;
      end
      ADDR_ALARM_IRQ_ENABLE: rdata[NUM_IRQ_SRC-1:0] = irq_en_q;
      ADDR_ALARM_IRQ_LATCHED: rdata[NUM_IRQ_SRC-1:0] = irq_lat_q;
      ADDR_ALARM_LIVE_STATE:
      begin
        rdata[BIT_DRIVER_FAIL] = alarm_in.driver_fail_alarm; // R11
        rdata[BIT_SIGNAL_LOSS] = alarm_in.signal_loss_alarm; // R12
        rdata[BIT_LOCK_LOSS] = alarm_in.lock_loss_alarm; // R13
        rdata[BIT_FIFO_EDGE] = fl_q; // R14
        rdata[BIT_ANALOG_LOSS] = alarm_in.analog_signal_loss; // R15
        rdata[BIT_DIGITAL_LOSS] = alarm_in.digital_signal_loss; // R16
        rdata[BIT_PATTERN_LIVE] = alarm_in.pattern_error_pulse; // R17
      end
      ADDR_GLOBAL_IRQ_ENABLE: rdata[BIT_GLOBAL] = gate_q;
      ADDR_GLOBAL_IRQ_STATE: rdata[BIT_GLOBAL] = pending; // R21
      ADDR_ERROR_COUNT_HIGH: rdata = err_cnt_q[15:8]; // R22
      ADDR_ERROR_COUNT_LOW: rdata = err_cnt_q[7:0]; // R22
      ADDR_PATTERN_HOLDING: rdata = hold_q;
      ADDR_PART_IDENTIFIER: rdata = PART_ID; // R18
      ADDR_REVISION_IDENTIFIER: rdata = REVISION_ID; // R18
      default: rdata = RST_BYTE;
    endcase
  end

  always_comb
  begin
    rx_on_d = rx_on_q;
    tx_on_d = tx_on_q;
    irq_en_d = irq_en_q;
    gate_d = gate_q;
    hold_d = hold_q;
    recentre_d = 1'b0;
    prev_d = live4;
    irq_lat_d = irq_lat_q;
    fl_d = fl_q;
    err_cnt_d = err_cnt_q;
    if (wr_stb)
    begin
      case (addr_q)
        ADDR_LINE_POWER_CONTROL:
        begin
          rx_on_d = wdata[BIT_RECEIVER_POWER_ON]; // R1
          tx_on_d = wdata[BIT_TRANSMITTER_POWER_ON]; // R2
        end
        ADDR_ALARM_IRQ_ENABLE: irq_en_d = wdata[NUM_IRQ_SRC-1:0];
        ADDR_GLOBAL_IRQ_ENABLE: gate_d = wdata[BIT_GLOBAL];
        default: gate_d = gate_q;
      endcase
    end
    if (rd_stb && rd_addr == ADDR_ALARM_IRQ_LATCHED)
      irq_lat_d = '0; // R8 R9 R10
    if (rd_stb && rd_addr == ADDR_ALARM_LIVE_STATE && fl_q)
    begin
      fl_d = 1'b0; // R20
      recentre_d = 1'b1; // R20
    end
    // Reading the high byte copies the low byte into the holding register for a coherent pair
    if (rd_stb && rd_addr == ADDR_ERROR_COUNT_HIGH)
      hold_d = err_cnt_q[7:0];
    // Hardware sets win over the read clear in the same cycle
    irq_lat_d = irq_lat_d | irq_evt;
    if (alarm_in.fifo_edge_raw)
      fl_d = 1'b1;
    if (alarm_in.pattern_error_pulse && err_cnt_q != ERR_COUNT_SAT)
      err_cnt_d = err_cnt_q + 16'h0001; // R22
    irq_n_d = ~(pending & gate_q); // R19 R21
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
      irq_en_q <= '0;
      irq_lat_q <= '0;
      gate_q <= 1'b0;
      prev_q <= 4'h0;
      fl_q <= 1'b0;
      recentre_q <= 1'b0;
      err_cnt_q <= ERR_COUNT_RST;
      hold_q <= RST_BYTE;
      irq_n_q <= 1'b1;
    end
    else
    begin
      rx_on_q <= rx_on_d;
      tx_on_q <= tx_on_d;
      irq_en_q <= irq_en_d;
      irq_lat_q <= irq_lat_d;
      gate_q <= gate_d;
      prev_q <= prev_d;
      fl_q <= fl_d;
      recentre_q <= recentre_d;
      err_cnt_q <= err_cnt_d;
      hold_q <= hold_d;
      irq_n_q <= irq_n_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb
  begin
    host_sdo = sdo_q;
    host_sdo_oe = sdo_oe_q;
    host_irq_n = irq_n_q;
    ctrl_out.receiver_power_on = rx_on_q;
    ctrl_out.transmitter_power_on = tx_on_q;
    ctrl_out.line_out_oe = tx_on_q; // R2
    ctrl_out.fifo_recentre = recentre_q;
  end

endmodule : airb_core

`default_nettype wire

// file: shared/airb_pkg.sv
// Package for the alarm and interrupt register bank: register offsets,
// field positions, reset values, serial frame layout and shared types.
// Assumes one 10 MHz register clock shared by all users of this package.
package airb_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_LINE_POWER_CONTROL = 7'h00;
  localparam logic [6:0] ADDR_ALARM_IRQ_ENABLE = 7'h01;
  localparam logic [6:0] ADDR_ALARM_IRQ_LATCHED = 7'h02;
  localparam logic [6:0] ADDR_ALARM_LIVE_STATE = 7'h03;
  localparam logic [6:0] ADDR_GLOBAL_IRQ_ENABLE = 7'h20;
  localparam logic [6:0] ADDR_GLOBAL_IRQ_STATE = 7'h21;
  localparam logic [6:0] ADDR_ERROR_COUNT_HIGH = 7'h30;
  localparam logic [6:0] ADDR_ERROR_COUNT_LOW = 7'h31;
  localparam logic [6:0] ADDR_PATTERN_HOLDING = 7'h38;
  localparam logic [6:0] ADDR_PART_IDENTIFIER = 7'h3e;
  localparam logic [6:0] ADDR_REVISION_IDENTIFIER = 7'h3f;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_TRANSMITTER_POWER_ON = 0;
  localparam int BIT_RECEIVER_POWER_ON = 4;
  localparam int BIT_DRIVER_FAIL = 0;
  localparam int BIT_SIGNAL_LOSS = 1;
  localparam int BIT_LOCK_LOSS = 2;
  localparam int BIT_FIFO_EDGE = 3;
  localparam int BIT_PATTERN_ERROR = 4;
  localparam int BIT_COUNTER_FULL = 5;
  localparam int BIT_ANALOG_LOSS = 4;
  localparam int BIT_DIGITAL_LOSS = 5;
  localparam int BIT_PATTERN_LIVE = 6;
  localparam int BIT_GLOBAL = 0;
  localparam int NUM_IRQ_SRC = 6;

  // ------------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] ERR_COUNT_RST = 16'h0000;
  localparam logic [15:0] ERR_COUNT_SAT = 16'hffff;

  // ------------------------------------------------------------------
  // Serial frame: 1 direction bit, 7 address bits, 8 data bits
  // ------------------------------------------------------------------
  localparam logic [3:0] HDR_LAST_BIT = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [3:0] BITCNT_RST = 4'h0;
  localparam logic [3:0] BITCNT_STEP = 4'h1;

  typedef enum logic [1:0] {
    AIRB_IDLE = 2'b00,
    AIRB_HDR = 2'b01,
    AIRB_DATA = 2'b11,
    AIRB_DONE = 2'b10
  } airb_state_t;

  // Live conditions reported by the line interface datapath
  typedef struct packed {
    logic driver_fail_alarm;
    logic signal_loss_alarm;
    logic lock_loss_alarm;
    logic fifo_edge_raw;
    logic analog_signal_loss;
    logic digital_signal_loss;
    logic pattern_error_pulse;
    logic jitter_atten_enabled;
  } airb_alarm_in_t;

  // Controls returned to the line interface datapath
  typedef struct packed {
    logic receiver_power_on;
    logic transmitter_power_on;
    logic line_out_oe;
    logic fifo_recentre;
  } airb_ctrl_out_t;

endpackage : airb_pkg

// file: verification/airb_monitor.sv
// Port-level checker for the alarm register bank.
// Assumes it is bound to airb_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module airb_monitor
  import airb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire airb_alarm_in_t alarm_in,
  input wire logic host_sclk,
  input wire logic host_sdi,
  input wire logic host_cs,
  input wire logic host_sdo,
  input wire logic host_sdo_oe,
  input wire logic host_irq_n,
  input wire airb_ctrl_out_t ctrl_out
);
  logic [3:0] cs_gap_q;
  logic [3:0] evt_gap_q;
  airb_alarm_in_t alarm_q;

  // Cycles since the host or the line last acted, saturating
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_gap_q <= 4'hf;
      evt_gap_q <= 4'hf;
      alarm_q <= '0;
    end
    else
    begin
      cs_gap_q <= host_cs ? 4'h0 : cs_gap_q + {3'h0, cs_gap_q != 4'hf};
      // A held error pulse is a fresh event on every cycle
      evt_gap_q <= (alarm_in != alarm_q || alarm_in.pattern_error_pulse) ? 4'h0 :
        evt_gap_q + {3'h0, evt_gap_q != 4'hf};
      alarm_q <= alarm_in;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_recentre;
    ctrl_out.fifo_recentre ##1 !ctrl_out.fifo_recentre;
  endsequence

  a_line_oe_tracks:
    assert property (ctrl_out.line_out_oe == ctrl_out.transmitter_power_on)
    else $error("line enable differs from transmitter on");
  a_recentre_single:
    assert property (ctrl_out.fifo_recentre |-> s_recentre)
    else $error("recentre longer than one cycle");
  a_recentre_in_read:
    assert property (ctrl_out.fifo_recentre |-> host_cs ##[0:2] host_sdo_oe)
    else $error("recentre outside a read");
  a_power_by_host:
    assert property (!$stable({ctrl_out.receiver_power_on, ctrl_out.transmitter_power_on})
      |-> cs_gap_q < 4'h8)
    else $error("power bits changed without a frame");
  a_irq_rise_cause:
    assert property ($rose(host_irq_n) |-> cs_gap_q < 4'h8 || evt_gap_q < 4'h4)
    else $error("interrupt released without cause");
  a_irq_fall_cause:
    assert property ($fell(host_irq_n) |-> cs_gap_q < 4'h8 || evt_gap_q < 4'h4)
    else $error("interrupt raised without cause");
  a_sdo_in_frame:
    assert property (host_sdo_oe |-> cs_gap_q < 4'h6)
    else $error("data out driven outside a frame");
  a_reset_quiet:
    assert property ($rose(rst_n) |-> (host_irq_n && !host_sdo_oe)[*8])
    else $error("outputs active just after reset");
endmodule : airb_monitor

`default_nettype wire

// file: verification/airb_host_model.sv
// Host processor model: drives 16-bit serial frames, MSB first.
// Assumes ref_clk is the bank clock; pins change at its falling edge.
`timescale 1ns/1ps
`default_nettype none

module airb_host_model
(
  input wire logic ref_clk,
  output logic host_sclk,
  output logic host_sdi,
  output logic host_cs,
  input wire logic host_sdo,
  input wire logic host_sdo_oe
);
  initial
  begin
    host_sclk = 1'b0;
    host_sdi = 1'b0;
    host_cs = 1'b0;
  end

  task automatic half(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : half

  // Read bits are taken just before each rise; an undriven line reads unknown
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] w,
                      output logic [7:0] r);
    logic [15:0] frm;
    frm = {rd, a, w};
    r = 8'h00;
    host_cs = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      host_sdi = frm[i];
      half(5);
      if (i < 8)
        r = {r[6:0], host_sdo_oe ? host_sdo : 1'bx};
      host_sclk = 1'b1;
      half(5);
      host_sclk = 1'b0;
    end
    host_cs = 1'b0;
    host_sdi = ~host_sdi;
    half(5);
  endtask : xfer
endmodule : airb_host_model

`default_nettype wire

// file: verification/tb_airb_core.sv
// Self-checking testbench for the alarm register bank.
// Assumes the package, core, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_airb_core
  import airb_pkg::*;
;
  // Arbitrary identification values
  localparam logic [7:0] PART = 8'h5a;
  localparam logic [7:0] REV = 8'h01;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  airb_alarm_in_t al = '0;
  logic sclk, sdi, cs, sdo, sdo_oe, irq_n;
  airb_ctrl_out_t ctrl;
  int failures = 0;
  int checks = 0;
  int nerr = 0;
  int recentres = 0;

  always #50 ref_clk = ~ref_clk;

  // Recentre is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge ref_clk)
    if (ctrl.fifo_recentre)
      recentres <= recentres + 1;

  airb_core #(.PART_ID(PART), .REVISION_ID(REV)) u_airb_core (.ref_clk(ref_clk),
    .rst_n(rst_n), .alarm_in(al), .host_sclk(sclk), .host_sdi(sdi), .host_cs(cs),
    .host_sdo(sdo), .host_sdo_oe(sdo_oe), .host_irq_n(irq_n), .ctrl_out(ctrl));
  airb_host_model u_airb_host_model (.ref_clk(ref_clk), .host_sclk(sclk),
    .host_sdi(sdi), .host_cs(cs), .host_sdo(sdo), .host_sdo_oe(sdo_oe));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_airb_host_model.xfer(1'b1, a, 8'h00, d);
    check($sformatf("reg %h", a), d, exp);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    u_airb_host_model.xfer(1'b0, a, v, d);
  endtask : wr

  task automatic irq_is(input logic exp_n);
    idle(4);
    check("irq_n", {7'h00, irq_n}, {7'h00, exp_n});
  endtask : irq_is

  // Back-to-back pulses, each one a bit error
  task automatic pat(input int n);
    al.pattern_error_pulse = 1'b1;
    idle(n);
    al.pattern_error_pulse = 1'b0;
    nerr = (nerr + n > 65535) ? 65535 : nerr + n;
  endtask : pat

  task automatic t_ident();
    irq_is(1'b1);
    rd(ADDR_LINE_POWER_CONTROL, 8'h00);
    rd(ADDR_ALARM_IRQ_ENABLE, 8'h00);
    rd(ADDR_ALARM_IRQ_LATCHED, 8'h00);
    rd(ADDR_GLOBAL_IRQ_STATE, 8'h00);
    rd(ADDR_PART_IDENTIFIER, PART);
    wr(ADDR_PART_IDENTIFIER, 8'h00);
    rd(ADDR_PART_IDENTIFIER, PART);
    rd(ADDR_REVISION_IDENTIFIER, REV);
    rd(7'h10, 8'h00);
  endtask : t_ident

  task automatic t_power();
    wr(ADDR_LINE_POWER_CONTROL, 8'h11);
    check("ctrl", {4'h0, ctrl}, 8'h0e);
    rd(ADDR_LINE_POWER_CONTROL, 8'h11);
    wr(ADDR_LINE_POWER_CONTROL, 8'h10);
    check("ctrl", {4'h0, ctrl}, 8'h08);
    wr(ADDR_LINE_POWER_CONTROL, 8'h01);
    check("ctrl", {4'h0, ctrl}, 8'h06);
  endtask : t_power

  task automatic t_levels();
    wr(ADDR_ALARM_IRQ_ENABLE, 8'h3f);
    wr(ADDR_GLOBAL_IRQ_ENABLE, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      al[7 - k] = 1'b1;
      irq_is(1'b0);
      rd(ADDR_ALARM_LIVE_STATE, 8'h01 << k);
      rd(ADDR_ALARM_IRQ_LATCHED, 8'h01 << k);
      irq_is(1'b1);
      al[7 - k] = 1'b0;
      rd(ADDR_ALARM_IRQ_LATCHED, 8'h01 << k);
    end
    al.analog_signal_loss = 1'b1;
    al.digital_signal_loss = 1'b1;
    rd(ADDR_ALARM_LIVE_STATE, 8'h30);
    al.analog_signal_loss = 1'b0;
    al.digital_signal_loss = 1'b0;
  endtask : t_levels

  task automatic t_mask();
    wr(ADDR_ALARM_IRQ_ENABLE, 8'h00);
    pat(1);
    irq_is(1'b1);
    rd(ADDR_GLOBAL_IRQ_STATE, 8'h00);
    wr(ADDR_ALARM_IRQ_ENABLE, 8'h10);
    irq_is(1'b0);
    rd(ADDR_GLOBAL_IRQ_STATE, 8'h01);
    wr(ADDR_GLOBAL_IRQ_ENABLE, 8'h00);
    irq_is(1'b1);
    wr(ADDR_GLOBAL_IRQ_ENABLE, 8'h01);
    rd(ADDR_ALARM_IRQ_LATCHED, 8'h10);
    irq_is(1'b1);
  endtask : t_mask

  task automatic t_count();
    wr(ADDR_ALARM_IRQ_ENABLE, 8'h20);
    pat(2);
    rd(ADDR_ERROR_COUNT_HIGH, nerr[15:8]);
    rd(ADDR_ERROR_COUNT_LOW, nerr[7:0]);
    pat(65540);
    irq_is(1'b0);
    rd(ADDR_ERROR_COUNT_HIGH, nerr[15:8]);
    rd(ADDR_PATTERN_HOLDING, nerr[7:0]);
    al.pattern_error_pulse = 1'b1;
    rd(ADDR_ALARM_LIVE_STATE, 8'h40);
    al.pattern_error_pulse = 1'b0;
    rd(ADDR_ALARM_IRQ_LATCHED, 8'h30);
    irq_is(1'b1);
  endtask : t_count

  task automatic t_fifo();
    wr(ADDR_ALARM_IRQ_ENABLE, 8'h08);
    al.fifo_edge_raw = 1'b1;
    idle(1);
    al.fifo_edge_raw = 1'b0;
    irq_is(1'b1);
    rd(ADDR_ALARM_IRQ_LATCHED, 8'h08);
    rd(ADDR_ALARM_LIVE_STATE, 8'h08);
    check("recentre", recentres[7:0], 8'h01);
    rd(ADDR_ALARM_LIVE_STATE, 8'h00);
    check("recentre", recentres[7:0], 8'h01);
    al.jitter_atten_enabled = 1'b1;
    al.fifo_edge_raw = 1'b1;
    idle(1);
    al.fifo_edge_raw = 1'b0;
    irq_is(1'b0);
  endtask : t_fifo

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // About 66k cycles of pulses plus 43 frames of about 165 cycles
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    idle(4);
    rst_n = 1'b1;
    idle(2);
    t_ident();
    t_power();
    t_levels();
    t_mask();
    t_count();
    t_fifo();
    report_and_stop();
  end
endmodule : tb_airb_core

bind airb_core airb_monitor u_airb_monitor (.ref_clk, .rst_n, .alarm_in, .host_sclk,
  .host_sdi, .host_cs, .host_sdo, .host_sdo_oe, .host_irq_n, .ctrl_out);

`default_nettype wire
